/* verilog/pbb_top.sv */
// Purpose: Accessory side of the plug-in backplane with AHB-Lite regs
// Assumes: Backplane inputs synchronous to ref_clk
// Notes: Open-drain outputs use oe_n, low means pulling the line low
// Notes on behaviour
// - Low reset line resets the accessory
// - Direction high reads, low writes
// - Respond only while own select low
// - Pulse acknowledge low to finish access
// - Five address lines, high means one
// - Sixteen bit bidirectional data bus
// - Poll low starts parallel poll
// - Poll response drives own slot data bit
// - Low trigger starts accessory action
// - General interrupt driven low to request
// - Normal scan interrupt driven low
// - Fast scan interrupt driven low
// - Opening line driven and sensed, held low
// - Closing line low while channel closes
// - Spare positions never driven nor used
// - Three supply status outputs to controller
// - Extender merges supplies onto one line
// - Shared wired failure line across extenders
// - Up to seven extenders, ten slots each
// - Supply lines high in normal operation
// - Mains reference only shortly after power
//
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module pbb_top
	import pbb_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Backplane inputs, spare positions absent
	input wire pbb_bp_in_type bp_in,
	// Backplane data bus
	output logic [15:0] data_out,
	output logic [15:0] data_oe_n,
	// Open-drain backplane lines
	output logic data_ack_n_oe_n,
	output logic general_irq_n_oe_n,
	output logic normal_scan_irq_n_oe_n,
	output logic fast_scan_irq_n_oe_n,
	output logic opening_oe_n,
	output logic closing_oe_n,
	// Trigger to accessory function
	output logic trigger_pulse,
	// Supply sense and status
	input wire logic raw_ok,
	input wire logic logic_ok,
	output logic raw_supply_good,
	output logic logic_supply_good,
	output logic mains_freq_ref,
	output logic ext_power_fail_oe_n
);
	// --------------------------------------------------------------
	// Reset release
	// --------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;

	// Two stage release of resetn
	// Assert at once, release on a clock edge to avoid recovery races
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_r <= 2'b00;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// Local reset also follows the backplane reset line
	logic bp_rst_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bp_rst_r <= 1'b1;
		end else begin
			bp_rst_r <= ~bp_in.reset_n;
		end
	end

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	logic [31:0] ctrl_r;
	logic [15:0] rdata_r;
	logic [15:0] wdata_r;
	logic [4:0] waddr_r;
	logic [4:0] slot_r;
	logic wr_seen_r;
	logic trig_seen_r;
	logic ph_wr_r;
	logic ph_rd_r;
	logic [7:0] ph_addr_r;
	logic st_sel;

	// Word decode helper
	function automatic logic known_ofs(input logic [7:0] a);
		known_ofs = (a == PBB_CTRL_OFS) || (a == PBB_STAT_OFS) ||
			(a == PBB_RDATA_OFS) || (a == PBB_WDATA_OFS) ||
			(a == PBB_WADDR_OFS) || (a == PBB_SLOT_OFS);
	endfunction

	// Transfer taken when selected, active and the bus is ready
	assign st_sel = hsel & hready & htrans[1];

	// Address phase capture
	// The data phase acts on what is held here, one cycle on
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_wr_r <= 1'b0;
			ph_rd_r <= 1'b0;
			ph_addr_r <= 8'h00;
		end else begin
			ph_wr_r <= st_sel & hwrite;
			ph_rd_r <= st_sel & ~hwrite;
			ph_addr_r <= haddr[7:0];
		end
	end

	// Writable registers
	// Backplane reset clears control, keeps read data and slot
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= PBB_CTRL_RST;
			rdata_r <= 16'h0000;
			slot_r <= PBB_SLOT_RST;
		end else if (bp_rst_r) begin
			ctrl_r <= PBB_CTRL_RST;
		end else if (ph_wr_r) begin
			if (ph_addr_r == PBB_CTRL_OFS)
				ctrl_r <= hwdata;
			if (ph_addr_r == PBB_RDATA_OFS)
				rdata_r <= hwdata[15:0];
			if (ph_addr_r == PBB_SLOT_OFS)
				slot_r <= hwdata[4:0];
		end
	end

	// Read mux
	// Status bits from 0: logic_ok, raw_ok, bp reset, direction,
	// selected, poll, trigger, opening sensed, write seen, trigger seen
	logic [31:0] stat_word;
	assign stat_word = {22'h00_0000, trig_seen_r, wr_seen_r,
		~bp_in.opening_in_n, ~bp_in.backplane_trigger_n,
		~bp_in.poll_request_n, ~bp_in.slot_sel_n,
		bp_in.bus_direction, bp_rst_r, raw_ok, logic_ok};

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (st_sel & ~hwrite) begin
			case (haddr[7:0])
				PBB_CTRL_OFS: hrdata <= ctrl_r;
				PBB_STAT_OFS: hrdata <= stat_word;
				PBB_RDATA_OFS: hrdata <= {16'h0000, rdata_r};
				PBB_WDATA_OFS: hrdata <= {16'h0000, wdata_r};
				PBB_WADDR_OFS: hrdata <= {27'h000_0000, waddr_r};
				PBB_SLOT_OFS: hrdata <= {27'h000_0000, slot_r};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Zero wait, always OKAY
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Access handshake
	// --------------------------------------------------------------
	pbb_state_type state_r;
	logic [1:0] ack_cnt_r;
	logic sel_act;
	logic rd_act;
	logic wr_ack;

	// Select counts only outside backplane reset
	assign sel_act = ~bp_in.slot_sel_n & ~bp_rst_r;
	assign rd_act = sel_act & bp_in.bus_direction;
	assign wr_ack = (state_r == PBB_IDLE) & sel_act;

	// Acknowledge pulse once per selection
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= PBB_IDLE;
			ack_cnt_r <= 2'b00;
		end else begin
			case (state_r)
				PBB_IDLE: begin
					if (sel_act) begin
						state_r <= PBB_ACK;
						ack_cnt_r <= 2'(PBB_ACK_LEN - 1);
					end
				end
				PBB_ACK: begin
					if (ack_cnt_r == 2'b00)
						state_r <= PBB_HOLD;
					else
						ack_cnt_r <= ack_cnt_r - 2'b01;
				end
				PBB_HOLD: begin
					// Wait for deselect so each select gives one pulse
					if (!sel_act)
						state_r <= PBB_IDLE;
				end
				default: state_r <= PBB_IDLE;
			endcase
		end
	end

	// Acknowledge pulled low from a flop while in the pulse state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_ack_n_oe_n <= 1'b1;
		end else begin
			data_ack_n_oe_n <= ~(state_r == PBB_ACK);
		end
	end

	// Capture written data and register number
	// Set wins over the clear by a WDATA read
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wdata_r <= 16'h0000;
			waddr_r <= 5'h00;
			wr_seen_r <= 1'b0;
		end else begin
			if (wr_ack & ~bp_in.bus_direction) begin
				wdata_r <= bp_in.data_in;
				waddr_r <= bp_in.reg_addr_lines;
				wr_seen_r <= 1'b1;
			end else if (ph_rd_r & (ph_addr_r == PBB_WDATA_OFS)) begin
				wr_seen_r <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// Data bus and poll response
	// --------------------------------------------------------------
	logic poll_act;
	logic [15:0] poll_bit;
	assign poll_act = ~bp_in.poll_request_n & ~bp_rst_r &
		ctrl_r[PBB_CTRL_SRQ];
	// Slots past bit 15, as on extenders, never answer a poll
	assign poll_bit = (slot_r < 5'd16) ?
		(16'h0001 << slot_r) : 16'h0000;

	// Read data has priority over the poll answer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= 16'h0000;
			data_oe_n <= 16'hFFFF;
		end else if (rd_act) begin
			data_out <= rdata_r;
			data_oe_n <= 16'h0000;
		end else if (poll_act) begin
			data_out <= 16'h0000;
			data_oe_n <= ~poll_bit;
		end else begin
			data_out <= 16'h0000;
			data_oe_n <= 16'hFFFF;
		end
	end

	// --------------------------------------------------------------
	// Interrupts, trigger, multiplexer lines
	// --------------------------------------------------------------
	logic trig_d_r;

	// Interrupt and multiplexer lines follow control bits
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			general_irq_n_oe_n <= 1'b1;
			normal_scan_irq_n_oe_n <= 1'b1;
			fast_scan_irq_n_oe_n <= 1'b1;
			opening_oe_n <= 1'b1;
			closing_oe_n <= 1'b1;
		end else begin
			general_irq_n_oe_n <= ~ctrl_r[PBB_CTRL_GP];
			normal_scan_irq_n_oe_n <= ~ctrl_r[PBB_CTRL_NS];
			fast_scan_irq_n_oe_n <= ~ctrl_r[PBB_CTRL_FS];
			opening_oe_n <= ~ctrl_r[PBB_CTRL_OPEN];
			closing_oe_n <= ~ctrl_r[PBB_CTRL_CLOSE];
		end
	end

	// Trigger edge to function, sticky seen flag, set wins
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_d_r <= 1'b0;
			trigger_pulse <= 1'b0;
			trig_seen_r <= 1'b0;
		end else begin
			trig_d_r <= ~bp_in.backplane_trigger_n;
			trigger_pulse <= ~bp_in.backplane_trigger_n & ~trig_d_r;
			if (~bp_in.backplane_trigger_n & ~trig_d_r)
				trig_seen_r <= 1'b1;
			else if (ph_rd_r & (ph_addr_r == PBB_STAT_OFS))
				trig_seen_r <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Supply status
	// --------------------------------------------------------------
	// Status outputs and mains reference come from the supply block
	pbb_supply u_supply (
		.clk(ref_clk),
		.rst_n(rst_n),
		.raw_ok(raw_ok),
		.logic_ok(logic_ok),
		.raw_supply_good(raw_supply_good),
		.logic_supply_good(logic_supply_good),
		.mains_freq_ref(mains_freq_ref),
		.ext_power_fail_oe_n(ext_power_fail_oe_n)
	);
endmodule

/* pkg/pbb_pkg.sv */
// Purpose: Shared constants and types for the accessory backplane logic
// Assumes: 40 MHz ref_clk, AHB-Lite register access
// Notes: Byte offsets of the word registers and field positions live here
package pbb_pkg;
	// --------------------------------------------------------------
	// Register map (byte offsets)
	// --------------------------------------------------------------
	localparam logic [7:0] PBB_CTRL_OFS = 8'h00;
	localparam logic [7:0] PBB_STAT_OFS = 8'h04;
	localparam logic [7:0] PBB_RDATA_OFS = 8'h08;
	localparam logic [7:0] PBB_WDATA_OFS = 8'h0C;
	localparam logic [7:0] PBB_WADDR_OFS = 8'h10;
	localparam logic [7:0] PBB_SLOT_OFS = 8'h14;
	// Control bits
	localparam int PBB_CTRL_GP = 0;
	localparam int PBB_CTRL_NS = 1;
	localparam int PBB_CTRL_FS = 2;
	localparam int PBB_CTRL_SRQ = 3;
	localparam int PBB_CTRL_OPEN = 4;
	localparam int PBB_CTRL_CLOSE = 5;
	localparam int PBB_CTRL_SUPON = 6;
	localparam logic [31:0] PBB_CTRL_RST = 32'h0000_0000;
	localparam logic [4:0] PBB_SLOT_RST = 5'h00;
	// Bus timing
	localparam int PBB_ACK_LEN = 2;
	// Mains reference: window in whole periods, half period in us
	// Window spans several periods so the wave is really seen
	localparam int PBB_CLK_MHZ = 40;
	localparam int PBB_REF_WIN_PER = 5;
	localparam int PBB_REF_HALF_US = 10000;
	localparam int PBB_REF_HALF_CYC = PBB_REF_HALF_US * PBB_CLK_MHZ;
	localparam int PBB_REF_WIN_CYC = PBB_REF_WIN_PER * 2 * PBB_REF_HALF_CYC;

	// Backplane pins seen by the accessory
	typedef struct packed {
		logic reset_n;
		logic bus_direction;
		logic slot_sel_n;
		logic [4:0] reg_addr_lines;
		logic [15:0] data_in;
		logic poll_request_n;
		logic backplane_trigger_n;
		logic opening_in_n;
	} pbb_bp_in_type;

	// Handshake state, Gray from IDLE through ACK to HOLD, both bits change on return to IDLE
	typedef enum logic [1:0] {
		PBB_IDLE = 2'b00,
		PBB_ACK = 2'b01,
		PBB_HOLD = 2'b11
	} pbb_state_type;
endpackage

/* verilog/pbb_supply.sv */
// Purpose: Supply status outputs and extender power merge
// Assumes: Synchronous supply inputs
// Notes: Reference runs only for a short window after power up
`timescale 1ns/1ps
module pbb_supply
	import pbb_pkg::*;
#(
	parameter int REF_WIN_CYC = PBB_REF_WIN_CYC,
	parameter int REF_HALF_CYC = PBB_REF_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Supply sense
	input wire logic raw_ok,
	input wire logic logic_ok,
	// Status out
	output logic raw_supply_good,
	output logic logic_supply_good,
	output logic mains_freq_ref,
	output logic ext_power_fail_oe_n
);
	logic [31:0] win_r;
	logic [31:0] half_r;

	// Supply lines high while up, merged onto shared line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			raw_supply_good <= 1'b0;
			logic_supply_good <= 1'b0;
			ext_power_fail_oe_n <= 1'b0;
		end else begin
			raw_supply_good <= raw_ok;
			logic_supply_good <= logic_ok;
			ext_power_fail_oe_n <= raw_ok & logic_ok;
		end
	end

	// Square wave for a short window only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			win_r <= 32'h0000_0000;
			half_r <= 32'h0000_0000;
			mains_freq_ref <= 1'b0;
		end else if (win_r < 32'(REF_WIN_CYC)) begin
			win_r <= win_r + 32'h0000_0001;
			if (half_r >= 32'(REF_HALF_CYC - 1)) begin
				half_r <= 32'h0000_0000;
				mains_freq_ref <= ~mains_freq_ref;
			end else begin
				half_r <= half_r + 32'h0000_0001;
			end
		end else begin
			mains_freq_ref <= 1'b0;
		end
	end
endmodule

/* bench/pbb_top_chk.sv */
// Purpose: Port checker for the backplane accessory logic
// Assumes: Bound to every pbb_top instance
// Notes: All checks are idle while resetn is low
`timescale 1ns/1ps
module pbb_top_chk
	import pbb_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Backplane side
	input wire pbb_bp_in_type bp_in,
	input wire logic [15:0] data_oe_n,
	input wire logic data_ack_n_oe_n,
	input wire logic trigger_pulse,
	// Supply side
	input wire logic raw_ok,
	input wire logic logic_ok,
	input wire logic raw_supply_good,
	input wire logic ext_power_fail_oe_n
);
	// ------------------------------------------------------------
	// Handshake and supply properties
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	// Acknowledge follows a fresh selection
	ack_after_sel_a: assert property (
		$fell(bp_in.slot_sel_n) && bp_in.reset_n |-> ##[1:4] !data_ack_n_oe_n)
		else $error("no acknowledge after select");
	ack_two_cyc_a: assert property (
		$fell(data_ack_n_oe_n) |=> !data_ack_n_oe_n ##1 data_ack_n_oe_n)
		else $error("acknowledge pulse not two cycles");
	ack_needs_sel_a: assert property (
		$fell(data_ack_n_oe_n) |-> !$past(bp_in.slot_sel_n))
		else $error("acknowledge without select");
	// Data driven only for a selected read or a poll answer
	drive_read_a: assert property (data_oe_n != 16'hffff |->
		!$past(bp_in.poll_request_n) || !$past(bp_in.slot_sel_n) &&
		$past(bp_in.bus_direction) || !$past(bp_in.slot_sel_n, 2))
		else $error("data driven while not read or poll");
	trig_pulse_a: assert property (
		trigger_pulse |-> !$past(bp_in.backplane_trigger_n) ##1 !trigger_pulse)
		else $error("trigger pulse wrong");
	ext_fail_a: assert property (
		!(raw_ok && logic_ok) [*4] |-> !ext_power_fail_oe_n)
		else $error("failure line not pulled");
	ext_good_a: assert property (
		(raw_ok && logic_ok) [*6] |-> ext_power_fail_oe_n)
		else $error("failure line pulled while good");
	raw_good_a: assert property (
		raw_ok [*6] |-> raw_supply_good)
		else $error("raw supply status low while up");
endmodule

bind pbb_top pbb_top_chk chk (.ref_clk, .resetn, .bp_in, .data_oe_n,
	.data_ack_n_oe_n, .trigger_pulse, .raw_ok, .logic_ok, .raw_supply_good,
	.ext_power_fail_oe_n);

/* bench/pbb_ctl_model.sv */
// Purpose: Local controller model driving the accessory backplane
// Assumes: Data lines carry pull-ups, acknowledge is open drain
// Notes: Bench sets poll, trigger and reset through field c
`timescale 1ns/1ps
module pbb_ctl_model
	import pbb_pkg::*;
(
	// Clock
	input wire logic clk,
	// Lines toward the accessory
	output pbb_bp_in_type bp,
	// Accessory drive
	input wire logic [15:0] acc_data,
	input wire logic [15:0] acc_oe_n,
	input wire logic ack_oe_n
);
	pbb_bp_in_type c;
	logic drv_r;
	logic [15:0] wd_r;
	// Idle: no reset, no select, no poll or trigger
	initial begin
		c = '1;
		drv_r = 1'h0;
		wd_r = 16'h0;
	end
	// Wired data bus, pull-up where nobody drives
	always_comb begin
		bp = c;
		bp.data_in = (acc_oe_n & (drv_r ? wd_r : 16'hffff)) |
			(~acc_oe_n & acc_data);
	end
	// One access: hold everything until acknowledge seen low
	task access(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] q, output logic ok);
		int n;
		@(posedge clk);
		c.bus_direction <= rd;
		c.reg_addr_lines <= ra;
		wd_r <= wd;
		drv_r <= !rd;
		c.slot_sel_n <= 1'h0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack_oe_n !== 1'h0 && n < 20);
		q = bp.data_in;
		ok = (n < 20);
		c.slot_sel_n <= 1'h1;
		drv_r <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
endmodule

/* bench/tb_plugin_backplane_bus.sv */
// Purpose: Self-checking bench for the backplane accessory logic
// Assumes: Zero wait AHB-Lite slave, 40 MHz ref_clk
// Notes: Mains reference is checked quiet early in the run
`timescale 1ns/1ps
module tb_plugin_backplane_bus;
	import pbb_pkg::*;
	typedef struct packed {
		logic wr;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} pbb_row_type;
	logic ref_clk = 1'h0, resetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q32;
	logic hready, hreadyout, hresp, raw_ok = 1'h1, logic_ok = 1'h1;
	logic [15:0] data_out, data_oe_n, q16;
	logic ack, gi, ni, fi, op, cl, tp, rg, lg, mf, ef;
	pbb_bp_in_type bp;
	int err_total = 0, check_count = 0, rises = 0;
	pbb_row_type rows [11] = '{
		'{1'h0, PBB_STAT_OFS, 32'h0, 32'hb},
		'{1'h0, PBB_CTRL_OFS, 32'h0, 32'h0}, '{1'h0, PBB_SLOT_OFS, 32'h0, 32'h0},
		'{1'h1, PBB_SLOT_OFS, 32'hff, 32'h0}, '{1'h0, PBB_SLOT_OFS, 32'h0, 32'h1f},
		'{1'h1, PBB_RDATA_OFS, 32'h5a3c, 32'h0},
		'{1'h0, PBB_RDATA_OFS, 32'h0, 32'h5a3c},
		'{1'h1, PBB_WDATA_OFS, 32'h1234, 32'h0},
		'{1'h0, PBB_WDATA_OFS, 32'h0, 32'h0},
		'{1'h1, 8'h40, 32'hffff_ffff, 32'h0}, '{1'h0, 8'h40, 32'h0, 32'h0}};
	assign hready = hreadyout;
	// Clock, 25 ns period
	always #12.5 ref_clk = ~ref_clk;
	// Count mains reference edges the controller would time from
	always @(posedge mf) rises++;
	pbb_top dut (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hreadyout, .hresp, .hrdata,
		.bp_in(bp), .data_out, .data_oe_n, .data_ack_n_oe_n(ack),
		.general_irq_n_oe_n(gi), .normal_scan_irq_n_oe_n(ni),
		.fast_scan_irq_n_oe_n(fi), .opening_oe_n(op), .closing_oe_n(cl),
		.trigger_pulse(tp), .raw_ok, .logic_ok, .raw_supply_good(rg),
		.logic_supply_good(lg), .mains_freq_ref(mf), .ext_power_fail_oe_n(ef));
	pbb_ctl_model ctl (.clk(ref_clk), .bp, .acc_data(data_out),
		.acc_oe_n(data_oe_n), .ack_oe_n(ack));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Wait for hready high at a rising edge, bounded
	task rdy;
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (hready !== 1'h1 && k < 20);
		if (k >= 20) begin
			err_total++;
			print_verdict;
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		rdy;
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		r = hrdata;
	endtask
	task bpa(input logic rd, input logic [4:0] ra, input logic [15:0] wd);
		logic ok;
		ctl.access(rd, ra, wd, q16, ok);
		chk(32'(ok), 32'h1);
		if (ok !== 1'h1) print_verdict;
	endtask
	task lines(input logic [4:0] e);
		repeat (3) @(posedge ref_clk);
		chk(32'({gi, ni, fi, op, cl}), 32'(e));
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge ref_clk);
		resetn <= 1'h1;
		repeat (4) @(posedge ref_clk);
		foreach (rows[i]) begin
			ahb(rows[i].wr, rows[i].a, rows[i].d, q32);
			if (!rows[i].wr) chk(q32, rows[i].e);
			chk(32'(hresp), 32'h0);
		end
		// Interrupt and multiplexer lines follow control bits
		ahb(1'h1, PBB_CTRL_OFS, 32'h37, q32);
		lines(5'h00);
		ahb(1'h1, PBB_CTRL_OFS, 32'h0, q32);
		lines(5'h1f);
		// Parallel poll answers on the slot's data bit
		ahb(1'h1, PBB_SLOT_OFS, 32'h3, q32);
		ahb(1'h1, PBB_CTRL_OFS, 32'h8, q32);
		ctl.c.poll_request_n <= 1'h0;
		repeat (3) @(posedge ref_clk);
		chk(32'(bp.data_in), 32'hfff7);
		ahb(1'h1, PBB_CTRL_OFS, 32'h0, q32);
		repeat (3) @(posedge ref_clk);
		chk(32'(bp.data_in), 32'hffff);
		ctl.c.poll_request_n <= 1'h1;
		// Backplane read then write
		bpa(1'h1, 5'h07, 16'h0);
		chk(32'(q16), 32'h5a3c);
		chk(32'(data_oe_n), 32'hffff);
		bpa(1'h0, 5'h15, 16'hc396);
		ahb(1'h0, PBB_WDATA_OFS, 32'h0, q32);
		chk(q32, 32'hc396);
		ahb(1'h0, PBB_WADDR_OFS, 32'h0, q32);
		chk(q32, 32'h15);
		// Trigger seen flag, cleared by reading status
		ctl.c.backplane_trigger_n <= 1'h0;
		repeat (2) @(posedge ref_clk);
		chk(32'(tp), 32'h1);
		@(posedge ref_clk);
		chk(32'(tp), 32'h0);
		@(posedge ref_clk);
		ctl.c.backplane_trigger_n <= 1'h1;
		ahb(1'h0, PBB_STAT_OFS, 32'h0, q32);
		chk(32'(q32[9]), 32'h1);
		ahb(1'h0, PBB_STAT_OFS, 32'h0, q32);
		chk(32'(q32[9]), 32'h0);
		// Supply status and merged failure line
		raw_ok <= 1'h0;
		repeat (8) @(posedge ref_clk);
		chk(32'({rg, lg, ef}), 32'h2);
		logic_ok <= 1'h0;
		raw_ok <= 1'h1;
		repeat (8) @(posedge ref_clk);
		chk(32'({rg, lg, ef}), 32'h4);
		logic_ok <= 1'h1;
		repeat (8) @(posedge ref_clk);
		chk(32'({rg, lg, ef}), 32'h7);
		// Reference still low: its first edge is half a period away
		chk(32'(rises == 0 && mf === 1'h0), 32'h1);
		// Backplane reset clears control
		ahb(1'h1, PBB_CTRL_OFS, 32'h3f, q32);
		lines(5'h00);
		ctl.c.reset_n <= 1'h0;
		repeat (3) @(posedge ref_clk);
		ctl.c.reset_n <= 1'h1;
		ahb(1'h0, PBB_CTRL_OFS, 32'h0, q32);
		chk(q32, 32'h0);
		lines(5'h1f);
		// Second asynchronous reset in mid-run
		ahb(1'h1, PBB_SLOT_OFS, 32'h5, q32);
		ahb(1'h0, PBB_SLOT_OFS, 32'h0, q32);
		chk(q32, 32'h5);
		resetn <= 1'h0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'h1;
		repeat (4) @(posedge ref_clk);
		ahb(1'h0, PBB_SLOT_OFS, 32'h0, q32);
		chk(q32, 32'h0);
		chk(32'({rg, lg, ef, mf}), 32'he);
		print_verdict;
	end
endmodule
